// [mcu_core_regs.sv]
/*
  Core registers, data RAM, ROM window, program counter, flags and stack.
  Assumes a decoder gives one pc_op and one flag_op per cycle, and that
  ROM and peripherals answer reads in the same cycle.
*/
`timescale 1ns/1ps

// Summary of operation
// RULE_01 - 8-bit accumulator, also at FFh
// RULE_02 - Pointer registers at 80h, 81h
// RULE_03 - Short-direct registers at 82h, 83h
// RULE_04 - 12-bit counter reaching 4096 bytes
// RULE_05 - Counter increments after each fetch
// RULE_06 - Relative branch adds signed offset
// RULE_07 - Counter loads jump, call, vector, reset, stack
// RULE_08 - Three flag pairs; only active pair changes
// RULE_09 - Interrupt switches pair; return restores prior (code restores it only after NMI; a maskable return always selects normal mode)
// RULE_10 - Mode switches never clear flags
// RULE_11 - Carry: arithmetic, tested bit, rotate
// RULE_12 - Zero set when result is zero
// RULE_13 - Reset starts in unmaskable mode
// RULE_14 - Six-level stack shifts down on push
// RULE_15 - Return pops level one, shifts up
// RULE_16 - Overflow holds depth, loses oldest
// RULE_17 - Return on empty stack keeps depth
// RULE_18 - 2K: user 0880h-0F9Fh, below 0800h absent
// RULE_19 - 4K: user 0080h-0F9Fh, low area reserved
// RULE_20 - Vectors 0FF0h-0FF7h, 0FFCh, 0FFEh
// RULE_21 - 64-byte window reads ROM constants
// RULE_22 - 60 RAM bytes, no bank register
// RULE_23 - Window: select high, address low six
// RULE_24 - Registers, flags, stack undefined after reset
module mcu_core_regs
#(
  parameter bit ROM_4K = 1'b1
)
(
  // Clock and reset
  input  wire logic                              ref_clk_i,
  input  wire logic                              rst_i,
  // Program counter control
  input  wire mcu_core_pkg::pc_op_e              pc_op_i,
  input  wire logic [mcu_core_pkg::PC_W-1:0]     target_i,
  input  wire logic [mcu_core_pkg::DATA_W-1:0]   offset_i,
  input  wire logic [2:0]                        vec_sel_i,
  // Program space
  output logic [mcu_core_pkg::PC_W-1:0]          prog_addr_o,
  output logic                                   pc_in_user_o,
  output logic                                   pc_implemented_o,
  // Data-space access
  input  wire logic [7:0]                        ds_addr_i,
  input  wire logic                              ds_rd_i,
  input  wire logic                              ds_wr_i,
  input  wire logic [mcu_core_pkg::DATA_W-1:0]   ds_wdata_i,
  output logic [mcu_core_pkg::DATA_W-1:0]        ds_rdata_o,
  // Peripheral registers outside this block
  output logic                                   ext_sel_o,
  input  wire logic [mcu_core_pkg::DATA_W-1:0]   ext_rdata_i,
  // Data-window port onto program ROM
  output logic [mcu_core_pkg::ROM_A_W-1:0]       data_rom_addr_o,
  input  wire logic [mcu_core_pkg::DATA_W-1:0]   data_rom_data_i,
  // ALU result and flag control
  input  wire mcu_core_pkg::flag_op_e            flag_op_i,
  input  wire logic [mcu_core_pkg::DATA_W-1:0]   alu_result_i,
  input  wire logic                              alu_carry_i,
  input  wire logic                              alu_acc_we_i,
  input  wire logic                              tested_bit_i,
  // Visible state
  output logic [mcu_core_pkg::DATA_W-1:0]        accumulator_o,
  output mcu_core_pkg::mode_e                    mode_o,
  output logic                                   carry_o,
  output logic                                   zero_o,
  output logic [mcu_core_pkg::DEPTH_W-1:0]       stack_depth_o,
  output logic                                   stack_empty_o
);

  localparam int DW = mcu_core_pkg::DATA_W;
  localparam int PW = mcu_core_pkg::PC_W;
  localparam int RN = mcu_core_pkg::RAM_N;

  // ==========
  // State
  typedef struct packed {
    logic [PW-1:0]                       pc;
    logic [DW-1:0]                       accumulator;
    logic [DW-1:0]                       pointer_reg_one;
    logic [DW-1:0]                       pointer_reg_two;
    logic [DW-1:0]                       short_direct_reg_one;
    logic [DW-1:0]                       short_direct_reg_two;
    logic [mcu_core_pkg::WIN_W-1:0]      rom_window_select;
    mcu_core_pkg::mode_e                 mode;
    mcu_core_pkg::mode_e                 nmi_prev_mode;
    logic [DW-1:0]                       rdata;
    logic [RN-1:0][DW-1:0]               ram;
  } core_state_s;

  core_state_s state;
  core_state_s next_state;

  // ==========
  // Submodule wiring
  logic          push;
  logic          pop;
  logic [PW-1:0] stack_top;
  logic          stack_empty;
  logic          carry;
  logic          zero;
  logic          carry_we;
  logic          next_carry;
  logic          zero_we;
  logic          next_zero;

  // ==========
  // Address decode
  logic       in_window;
  logic       in_ram;
  logic [7:0] ram_index;
  logic       internal;

  assign in_window = (ds_addr_i >= mcu_core_pkg::WIN_FIRST)
                  && (ds_addr_i <= mcu_core_pkg::WIN_LAST);
  // Whole space fits in eight address bits, so no bank register exists
  assign in_ram    = (ds_addr_i >= mcu_core_pkg::RAM_FIRST)
                  && (ds_addr_i <= mcu_core_pkg::RAM_LAST); // see RULE_22
  assign ram_index = ds_addr_i - mcu_core_pkg::RAM_FIRST;
  assign internal  = in_window || in_ram
                  || (ds_addr_i == mcu_core_pkg::ADDR_PTR_ONE)
                  || (ds_addr_i == mcu_core_pkg::ADDR_PTR_TWO)
                  || (ds_addr_i == mcu_core_pkg::ADDR_SHORT_ONE)
                  || (ds_addr_i == mcu_core_pkg::ADDR_SHORT_TWO)
                  || (ds_addr_i == mcu_core_pkg::ADDR_ACC)
                  || (ds_addr_i == mcu_core_pkg::ADDR_ROM_WIN);

  assign ext_sel_o = (ds_rd_i || ds_wr_i) && !internal;

  // Window register is cleared at reset only to avoid X: software must load it before first use
  assign data_rom_addr_o = {state.rom_window_select,
                            ds_addr_i[mcu_core_pkg::WIN_LO_W-1:0]}; // see RULE_23

  // ==========
  // Flag sources
  always_comb
  begin
    carry_we   = 1'b0;
    next_carry = carry;
    zero_we    = 1'b0;
    next_zero  = zero;
    unique case (flag_op_i)
      mcu_core_pkg::FLAG_NONE:
      begin
      end
      mcu_core_pkg::FLAG_ARITH:
      begin
        carry_we   = 1'b1;
        next_carry = alu_carry_i; // see RULE_11
        zero_we    = 1'b1;
        next_zero  = (alu_result_i == '0); // see RULE_12
      end
      mcu_core_pkg::FLAG_LOGIC:
      begin
        zero_we    = 1'b1;
        next_zero  = (alu_result_i == '0); // see RULE_12
      end
      mcu_core_pkg::FLAG_BITTEST:
      begin
        carry_we   = 1'b1;
        next_carry = tested_bit_i; // see RULE_11
      end
      mcu_core_pkg::FLAG_ROTATE:
      begin
        carry_we   = 1'b1;
        next_carry = state.accumulator[DW-1]; // see RULE_11
        zero_we    = 1'b1;
        next_zero  = ({state.accumulator[DW-2:0], carry} == '0);
      end
      default:
      begin
      end
    endcase
  end

  // ==========
  // Program counter, mode and data-space registers
  always_comb
  begin
    next_state = state;
    push       = 1'b0;
    pop        = 1'b0;

    unique case (pc_op_i)
      mcu_core_pkg::PC_HOLD:
      begin
      end
      mcu_core_pkg::PC_INC:
      begin
        next_state.pc = state.pc + 1'b1; // see RULE_05
      end
      mcu_core_pkg::PC_JUMP:
      begin
        next_state.pc = target_i; // see RULE_07
      end
      mcu_core_pkg::PC_CALL:
      begin
        push          = 1'b1; // see RULE_14
        next_state.pc = target_i; // see RULE_07
      end
      mcu_core_pkg::PC_REL:
      begin
        next_state.pc = state.pc + {{(PW-DW){offset_i[DW-1]}}, offset_i}; // see RULE_06
      end
      mcu_core_pkg::PC_VECTOR:
      begin
        push = 1'b1; // see RULE_14
        if (vec_sel_i == mcu_core_pkg::VEC_SEL_NMI)
        begin
          next_state.pc            = mcu_core_pkg::VEC_NMI; // see RULE_20
          next_state.nmi_prev_mode = state.mode;
          next_state.mode          = mcu_core_pkg::MODE_NMI; // see RULE_09
        end
        else
        begin
          // Vector n of the maskable group sits at top minus 2n
          next_state.pc   = mcu_core_pkg::VEC_IRQ_TOP
                          - {8'h00, vec_sel_i, 1'b0}; // see RULE_20
          next_state.mode = mcu_core_pkg::MODE_IRQ; // see RULE_09
        end
      end
      mcu_core_pkg::PC_RET:
      begin
        pop = 1'b1; // see RULE_15
        // Empty stack: counter already points past the return
        if (!stack_empty)
        begin
          next_state.pc = stack_top; // see RULE_07
        end
      end
      mcu_core_pkg::PC_INTERRUPT_RETURN_OP:
      begin
        pop = 1'b1; // see RULE_15
        if (!stack_empty)
        begin
          next_state.pc = stack_top; // see RULE_17
        end
        if (state.mode == mcu_core_pkg::MODE_NMI)
        begin
          next_state.mode = state.nmi_prev_mode; // see RULE_09
        end
        else
        begin
          next_state.mode = mcu_core_pkg::MODE_NORMAL; // see RULE_09
        end
      end
      default:
      begin
      end
    endcase

    // Data-space writes
    if (ds_wr_i)
    begin
      if (in_ram)
      begin
        next_state.ram[ram_index[5:0]] = ds_wdata_i; // see RULE_22
      end
      unique case (ds_addr_i)
        mcu_core_pkg::ADDR_PTR_ONE:   next_state.pointer_reg_one      = ds_wdata_i; // see RULE_02
        mcu_core_pkg::ADDR_PTR_TWO:   next_state.pointer_reg_two      = ds_wdata_i; // see RULE_02
        mcu_core_pkg::ADDR_SHORT_ONE: next_state.short_direct_reg_one = ds_wdata_i; // see RULE_03
        mcu_core_pkg::ADDR_SHORT_TWO: next_state.short_direct_reg_two = ds_wdata_i; // see RULE_03
        mcu_core_pkg::ADDR_ACC:       next_state.accumulator          = ds_wdata_i; // see RULE_01
        mcu_core_pkg::ADDR_ROM_WIN:
        begin
          next_state.rom_window_select = ds_wdata_i[mcu_core_pkg::WIN_W-1:0]; // see RULE_23
        end
        default:
        begin
        end
      endcase
    end

    // ALU writes to the accumulator take priority over a bus write
    if (flag_op_i == mcu_core_pkg::FLAG_ROTATE)
    begin
      next_state.accumulator = {state.accumulator[DW-2:0], carry}; // see RULE_11
    end
    else if (alu_acc_we_i)
    begin
      next_state.accumulator = alu_result_i; // see RULE_01
    end

    // Data-space reads, answered one cycle later from a register
    if (ds_rd_i)
    begin
      if (in_window)
      begin
        next_state.rdata = data_rom_data_i; // see RULE_21
      end
      else if (in_ram)
      begin
        next_state.rdata = state.ram[ram_index[5:0]];
      end
      else
      begin
        unique case (ds_addr_i)
          mcu_core_pkg::ADDR_PTR_ONE:   next_state.rdata = state.pointer_reg_one; // see RULE_02
          mcu_core_pkg::ADDR_PTR_TWO:   next_state.rdata = state.pointer_reg_two;
          mcu_core_pkg::ADDR_SHORT_ONE: next_state.rdata = state.short_direct_reg_one;
          mcu_core_pkg::ADDR_SHORT_TWO: next_state.rdata = state.short_direct_reg_two;
          mcu_core_pkg::ADDR_ACC:       next_state.rdata = state.accumulator; // see RULE_01
          // Write-only: software cannot read back the window select
          mcu_core_pkg::ADDR_ROM_WIN:   next_state.rdata = mcu_core_pkg::WO_READ_VALUE;
          default:                      next_state.rdata = ext_rdata_i;
        endcase
      end
    end
  end

  // ==========
  // Registers
  // Working registers are cleared only to avoid X; software sees them undefined
  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
    begin
      state      <= '0; // see RULE_24
      state.pc   <= mcu_core_pkg::VEC_RESET; // see RULE_07
      state.mode <= mcu_core_pkg::MODE_NMI; // see RULE_13
      state.nmi_prev_mode <= mcu_core_pkg::MODE_NORMAL;
    end
    else
    begin
      state <= next_state;
    end
  end

  // ==========
  // Submodules
  return_stack #(
    .DEPTH       (mcu_core_pkg::STACK_N)
  ) u_stack (
    .ref_clk_i   (ref_clk_i),
    .rst_i       (rst_i),
    .push_i      (push),
    .pop_i       (pop),
    .push_addr_i (state.pc),
    .top_o       (stack_top),
    .empty_o     (stack_empty),
    .depth_o     (stack_depth_o)
  );

  flag_bank u_flags (
    .ref_clk_i   (ref_clk_i),
    .rst_i       (rst_i),
    .mode_i      (state.mode),
    .carry_we_i  (carry_we),
    .carry_i     (next_carry),
    .zero_we_i   (zero_we),
    .zero_i      (next_zero),
    .carry_o     (carry),
    .zero_o      (zero)
  );

  // ==========
  // Outputs
  assign prog_addr_o   = state.pc; // see RULE_04
  assign ds_rdata_o    = state.rdata;
  assign accumulator_o = state.accumulator;
  assign mode_o        = state.mode;
  assign carry_o       = carry;
  assign zero_o        = zero;
  assign stack_empty_o = stack_empty;

  // Program-space map for the two ROM sizes
  always_comb
  begin
    if (ROM_4K)
    begin
      pc_implemented_o = 1'b1;
      pc_in_user_o     = (state.pc >= mcu_core_pkg::USER_LO_4K)
                      && (state.pc <= mcu_core_pkg::USER_HI); // see RULE_19
    end
    else
    begin
      pc_implemented_o = (state.pc >= mcu_core_pkg::IMPL_LO_2K); // see RULE_18
      pc_in_user_o     = (state.pc >= mcu_core_pkg::USER_LO_2K)
                      && (state.pc <= mcu_core_pkg::USER_HI); // see RULE_18
    end
  end

endmodule : mcu_core_regs

// [mcu_core_pkg.sv]
/*
  Constants and encodings for the core register block.
  Assumes one core clock and a data space under 256 bytes.
*/
package mcu_core_pkg;

  // ==========
  // Widths
  localparam int DATA_W   = 8;
  localparam int PC_W     = 12;
  localparam int ROM_A_W  = 13;
  localparam int WIN_W    = 7;
  localparam int WIN_LO_W = 6;
  localparam int STACK_N  = 6;
  localparam int DEPTH_W  = 3;
  localparam int RAM_N    = 60;

  // ==========
  // Data-space map
  localparam logic [7:0] ADDR_PTR_ONE   = 8'h80;
  localparam logic [7:0] ADDR_PTR_TWO   = 8'h81;
  localparam logic [7:0] ADDR_SHORT_ONE = 8'h82;
  localparam logic [7:0] ADDR_SHORT_TWO = 8'h83;
  localparam logic [7:0] ADDR_ACC       = 8'hff;
  localparam logic [7:0] ADDR_ROM_WIN   = 8'hc9;
  localparam logic [7:0] WIN_FIRST      = 8'h40;
  localparam logic [7:0] WIN_LAST       = 8'h7f;
  localparam logic [7:0] RAM_FIRST      = 8'h84;
  localparam logic [7:0] RAM_LAST       = 8'hbf;
  localparam logic [7:0] WO_READ_VALUE  = 8'h00;

  // ==========
  // Program-space map and vectors
  localparam logic [11:0] USER_LO_2K   = 12'h880;
  localparam logic [11:0] USER_LO_4K   = 12'h080;
  localparam logic [11:0] USER_HI      = 12'hf9f;
  localparam logic [11:0] IMPL_LO_2K   = 12'h800;
  localparam logic [11:0] VEC_IRQ_TOP  = 12'hff8;
  localparam logic [11:0] VEC_IRQ_LO   = 12'hff0;
  localparam logic [11:0] VEC_NMI      = 12'hffc;
  localparam logic [11:0] VEC_RESET    = 12'hffe;
  localparam logic [2:0]  VEC_SEL_NMI  = 3'h0;

  // ==========
  // Encodings
  typedef enum logic [2:0] {
    MODE_NORMAL = 3'b001,
    MODE_IRQ    = 3'b010,
    MODE_NMI    = 3'b100
  } mode_e;

  typedef enum logic [7:0] {
    PC_HOLD   = 8'b0000_0001,
    PC_INC    = 8'b0000_0010,
    PC_JUMP   = 8'b0000_0100,
    PC_CALL   = 8'b0000_1000,
    PC_REL    = 8'b0001_0000,
    PC_VECTOR = 8'b0010_0000,
    PC_RET    = 8'b0100_0000,
    PC_INTERRUPT_RETURN_OP   = 8'b1000_0000
  } pc_op_e;

  typedef enum logic [4:0] {
    FLAG_NONE    = 5'b00001,
    FLAG_ARITH   = 5'b00010,
    FLAG_LOGIC   = 5'b00100,
    FLAG_BITTEST = 5'b01000,
    FLAG_ROTATE  = 5'b10000
  } flag_op_e;

endpackage : mcu_core_pkg

// [flag_bank.sv]
/*
  Three carry/zero flag pairs, one per mode.
  Assumes a one-hot mode input.
*/
`timescale 1ns/1ps
module flag_bank
(
  // Clock and reset
  input  wire logic                  ref_clk_i,
  input  wire logic                  rst_i,
  // Mode and updates
  input  wire mcu_core_pkg::mode_e   mode_i,
  input  wire logic                  carry_we_i,
  input  wire logic                  carry_i,
  input  wire logic                  zero_we_i,
  input  wire logic                  zero_i,
  // Active pair
  output logic                       carry_o,
  output logic                       zero_o
);

  typedef struct packed {
    logic [2:0] carry;
    logic [2:0] zero;
  } flag_state_s;

  flag_state_s state;
  flag_state_s next_state;

  // ==========
  // Update
  // Pairs are never cleared on a mode switch, only by their own routine
  always_comb
  begin
    next_state = state;
    for (int i = 0; i < 3; i++)
    begin
      if (mode_i[i] && carry_we_i)
      begin
        next_state.carry[i] = carry_i; // see RULE_08
      end
      if (mode_i[i] && zero_we_i)
      begin
        next_state.zero[i] = zero_i; // see RULE_10
      end
    end
  end

  // Reset value is arbitrary for software purposes
  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
    begin
      state <= '0;
    end
    else
    begin
      state <= next_state;
    end
  end

  assign carry_o = |(state.carry & mode_i); // see RULE_08
  assign zero_o  = |(state.zero & mode_i);

endmodule : flag_bank

// [return_stack.sv]
/*
  Six-level return stack of program addresses.
  Assumes push and pop never come together.
*/
`timescale 1ns/1ps
module return_stack
#(
  parameter int DEPTH = mcu_core_pkg::STACK_N
)
(
  // Clock and reset
  input  wire logic                          ref_clk_i,
  input  wire logic                          rst_i,
  // Control
  input  wire logic                          push_i,
  input  wire logic                          pop_i,
  input  wire logic [mcu_core_pkg::PC_W-1:0] push_addr_i,
  // Status
  output logic [mcu_core_pkg::PC_W-1:0]      top_o,
  output logic                               empty_o,
  output logic [mcu_core_pkg::DEPTH_W-1:0]   depth_o
);

  typedef struct packed {
    logic [DEPTH-1:0][mcu_core_pkg::PC_W-1:0] level;
    logic [mcu_core_pkg::DEPTH_W-1:0]         depth;
  } stack_state_s;

  stack_state_s state;
  stack_state_s next_state;

  localparam logic [mcu_core_pkg::DEPTH_W-1:0] FULL = mcu_core_pkg::DEPTH_W'(DEPTH);

  // ==========
  // Shift logic
  always_comb
  begin
    next_state = state;
    if (push_i)
    begin
      for (int i = DEPTH - 1; i > 0; i--)
      begin
        next_state.level[i] = state.level[i-1]; // see RULE_14
      end
      next_state.level[0] = push_addr_i;
      if (state.depth != FULL)
      begin
        next_state.depth = state.depth + 1'b1; // see RULE_16
      end
    end
    else if (pop_i && (state.depth != '0)) // see RULE_17
    begin
      for (int i = 0; i < DEPTH - 1; i++)
      begin
        next_state.level[i] = state.level[i+1]; // see RULE_15
      end
      next_state.depth = state.depth - 1'b1;
    end
  end

  // Contents are left as they are at reset; only the depth is defined
  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
    begin
      state.depth <= '0;
    end
    else
    begin
      state <= next_state;
    end
  end

  assign top_o   = state.level[0];
  assign empty_o = (state.depth == '0);
  assign depth_o = state.depth;

endmodule : return_stack

// [mcu_core_regs_props.sv]
/*
  Checker for mcu_core_regs: counter loads, stack depth, modes, window.
  Assumes a bind to the top module; it sees only that module's ports.
*/
`timescale 1ns/1ps
module mcu_core_regs_props
(
  // Clock and reset
  input wire logic                 ref_clk_i,
  input wire logic                 rst_i,
  // Watched ports
  input wire mcu_core_pkg::pc_op_e pc_op_i,
  input wire logic [11:0]          target_i,
  input wire logic [7:0]           offset_i,
  input wire logic [2:0]           vec_sel_i,
  input wire logic [11:0]          prog_addr_o,
  input wire logic [7:0]           ds_addr_i,
  input wire logic [12:0]          data_rom_addr_o,
  input wire mcu_core_pkg::mode_e  mode_o,
  input wire logic [2:0]           stack_depth_o,
  input wire logic                 stack_empty_o
);
  // ==========
  // Properties
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  property p_rst; $fell(rst_i) |-> prog_addr_o == 12'hffe && mode_o == 3'b100; endproperty
  a_rst: assert property (p_rst) else $error("reset state");
  property p_jmp; pc_op_i inside {8'h04, 8'h08} |=> prog_addr_o == $past(target_i); endproperty
  a_jmp: assert property (p_jmp) else $error("jump load");
  property p_inc; pc_op_i == 8'h02 |=> prog_addr_o == $past(prog_addr_o) + 12'h001; endproperty
  a_inc: assert property (p_inc) else $error("increment");
  property p_rel;
    pc_op_i == 8'h10 |=> prog_addr_o == $past(prog_addr_o) + 12'($signed($past(offset_i)));
  endproperty
  a_rel: assert property (p_rel) else $error("relative");
  property p_psh; pc_op_i == 8'h08 && stack_depth_o < 3'd6 |=> $rose(!stack_empty_o) ||
    stack_depth_o == $past(stack_depth_o) + 3'd1; endproperty
  a_psh: assert property (p_psh) else $error("push depth");
  property p_full; pc_op_i == 8'h08 && stack_depth_o == 3'd6 |=> stack_depth_o == 3'd6; endproperty
  a_full: assert property (p_full) else $error("full depth");
  property p_pop; pc_op_i == 8'h40 && !stack_empty_o |=>
    stack_depth_o == $past(stack_depth_o) - 3'd1; endproperty
  a_pop: assert property (p_pop) else $error("pop depth");
  property p_mt; pc_op_i == 8'h40 && stack_empty_o |=> $stable(prog_addr_o) && stack_empty_o;
  endproperty
  a_mt: assert property (p_mt) else $error("empty return");
  property p_vec; pc_op_i == 8'h20 && vec_sel_i inside {[3'h1:3'h4]} |=> mode_o == 3'b010 &&
    prog_addr_o == 12'hff8 - {$past(vec_sel_i), 1'b0}; endproperty
  a_vec: assert property (p_vec) else $error("irq vector");
  property p_nmi; pc_op_i == 8'h20 && vec_sel_i == 3'h0 |=> prog_addr_o == 12'hffc &&
    mode_o == 3'b100; endproperty
  a_nmi: assert property (p_nmi) else $error("nmi vector");
  property p_win; ds_addr_i[7:6] == 2'b01 |-> data_rom_addr_o[5:0] == ds_addr_i[5:0]; endproperty
  a_win: assert property (p_win) else $error("window addr");
endmodule : mcu_core_regs_props

// [mem_side_model.sv]
/*
  Far side: program ROM on the data-window port and peripheral registers.
  Assumes the core samples both answers in the cycle of the access.
*/
`timescale 1ns/1ps
module mem_side_model
(
  // Clock
  input  wire logic        ref_clk_i,
  // Requests
  input  wire logic [12:0] rom_addr_i,
  input  wire logic        ext_sel_i,
  // Answers
  output logic [7:0]       rom_data_o,
  output logic [7:0]       ext_data_o
);
  logic [7:0] idle_q = 8'h00;
  // Unselected bus churns so a stale byte never looks valid
  always @(posedge ref_clk_i) idle_q <= idle_q + 8'h01;
  assign rom_data_o = rom_addr_i[7:0] ^ {3'h0, rom_addr_i[12:8]};
  assign ext_data_o = ext_sel_i ? 8'h3c : idle_q;
endmodule : mem_side_model

// [mcu_core_regs_tb.sv]
/*
  Testbench for mcu_core_regs: flags, data-space map, counter and stack.
  Assumes the far-side model answers window and peripheral reads at once.
*/
`timescale 1ns/1ps
module mcu_core_regs_tb;
  logic                   ref_clk_i = 1'b0;
  logic                   rst_i = 1'b1;
  mcu_core_pkg::pc_op_e   pc_op_i = mcu_core_pkg::PC_HOLD;
  mcu_core_pkg::flag_op_e flag_op_i = mcu_core_pkg::FLAG_NONE;
  logic [11:0]            target_i = 12'h000;
  logic [7:0]             offset_i = 8'h00, ds_addr_i = 8'h00, ds_wdata_i = 8'h00;
  logic [7:0]             alu_result_i = 8'h00, ds_rdata_o, ext_rdata_i, data_rom_data_i;
  logic [2:0]             vec_sel_i = 3'h0, stack_depth_o;
  logic                   ds_rd_i = 1'b0, ds_wr_i = 1'b0, alu_carry_i = 1'b0;
  logic                   alu_acc_we_i = 1'b0, tested_bit_i = 1'b0, ext_sel_o, carry_o, zero_o;
  logic                   stack_empty_o, pc_in_user_o, pc_implemented_o;
  logic [11:0]            prog_addr_o;
  logic [7:0]             accumulator_o;
  logic [12:0]            data_rom_addr_o;
  mcu_core_pkg::mode_e    mode_o;
  int                     err_count = 0, n_checks = 0;
  always #4 ref_clk_i = ~ref_clk_i;
  mcu_core_regs u_mcu_core_regs (.*);
  mem_side_model u_mem_side_model (.ref_clk_i(ref_clk_i), .rom_addr_i(data_rom_addr_o),
    .ext_sel_i(ext_sel_o), .rom_data_o(data_rom_data_i), .ext_data_o(ext_rdata_i));
  // ==========
  // Drivers
  task automatic chk(input logic [11:0] s, input logic [11:0] e);
    n_checks++;
    if (s !== e)
    begin
      err_count++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, s, e);
    end
  endtask : chk
  task automatic pc(input mcu_core_pkg::pc_op_e op, input logic [11:0] t = 12'h000,
                    input logic [2:0] s = 3'h0);
    @(negedge ref_clk_i);
    pc_op_i = op;
    target_i = t;
    vec_sel_i = s;
    @(negedge ref_clk_i);
    pc_op_i = mcu_core_pkg::PC_HOLD;
  endtask : pc
  task automatic ds(input logic [7:0] a, input logic w, input logic [7:0] d);
    @(negedge ref_clk_i);
    ds_addr_i = a;
    ds_wr_i = w;
    ds_rd_i = !w;
    ds_wdata_i = d;
    @(negedge ref_clk_i);
    ds_wr_i = 1'b0;
    ds_rd_i = 1'b0;
  endtask : ds
  task automatic fl(input mcu_core_pkg::flag_op_e op, input logic [7:0] r, input logic c,
                    input logic we = 1'b0);
    @(negedge ref_clk_i);
    flag_op_i = op;
    alu_result_i = r;
    alu_carry_i = c;
    tested_bit_i = c;
    alu_acc_we_i = we;
    @(negedge ref_clk_i);
    flag_op_i = mcu_core_pkg::FLAG_NONE;
    alu_acc_we_i = 1'b0;
  endtask : fl
  // ==========
  // Scenarios
  task automatic t_flags;
    chk(prog_addr_o, 12'hffe);
    chk(12'({mode_o, stack_empty_o}), 12'h009);
    chk(12'({pc_in_user_o, pc_implemented_o}), 12'h001);
    fl(mcu_core_pkg::FLAG_ARITH, 8'h00, 1'b1);
    chk(12'({carry_o, zero_o}), 12'h003);
    pc(mcu_core_pkg::PC_INTERRUPT_RETURN_OP);
    chk(12'(mode_o), 12'h001);
    fl(mcu_core_pkg::FLAG_ARITH, 8'h05, 1'b0);
    chk(12'({carry_o, zero_o}), 12'h000);
    pc(mcu_core_pkg::PC_VECTOR, 12'h000, 3'h1);
    fl(mcu_core_pkg::FLAG_BITTEST, 8'h05, 1'b1);
    fl(mcu_core_pkg::FLAG_LOGIC, 8'h00, 1'b0);
    chk(12'({carry_o, zero_o, mode_o}), 12'h01a);
    pc(mcu_core_pkg::PC_INTERRUPT_RETURN_OP);
    chk(12'({carry_o, zero_o, mode_o}), 12'h001);
    pc(mcu_core_pkg::PC_VECTOR);
    chk(12'({carry_o, zero_o, mode_o}), 12'h01c);
    pc(mcu_core_pkg::PC_INTERRUPT_RETURN_OP);
    chk(12'(mode_o), 12'h001);
    ds(8'hff, 1'b1, 8'h81);
    fl(mcu_core_pkg::FLAG_ROTATE, 8'h00, 1'b0);
    chk(12'({carry_o, zero_o, accumulator_o}), 12'h202);
    fl(mcu_core_pkg::FLAG_LOGIC, 8'h00, 1'b0, 1'b1);
    chk(12'(accumulator_o), 12'h000);
  endtask : t_flags
  task automatic t_regs;
    logic [7:0] m [7] = '{8'h80, 8'h81, 8'h82, 8'h83, 8'h84, 8'hbf, 8'hff};
    foreach (m[i]) ds(m[i], 1'b1, m[i] ^ 8'h5a);
    foreach (m[i])
    begin
      ds(m[i], 1'b0, 8'h00);
      chk(12'(ds_rdata_o), 12'(m[i] ^ 8'h5a));
    end
    ds(8'hc9, 1'b1, 8'h05);
    ds(8'h4a, 1'b0, 8'h00);
    chk(12'(ds_rdata_o), 12'h04b);
    ds(8'hc9, 1'b0, 8'h00);
    chk(12'(ds_rdata_o), 12'h000);
    ds(8'hc0, 1'b0, 8'h00);
    chk(12'(ds_rdata_o), 12'h03c);
  endtask : t_regs
  task automatic t_pc;
    pc(mcu_core_pkg::PC_JUMP, 12'h200);
    chk({pc_in_user_o, prog_addr_o[10:0]}, 12'ha00);
    pc(mcu_core_pkg::PC_INC);
    chk(prog_addr_o, 12'h201);
    offset_i = 8'hfe;
    pc(mcu_core_pkg::PC_REL);
    chk(prog_addr_o, 12'h1ff);
    for (int i = 0; i < 7; i++) pc(mcu_core_pkg::PC_CALL, 12'h300 + 12'(i));
    chk(12'(stack_depth_o), 12'h006);
    for (int i = 5; i >= 0; i--)
    begin
      pc(mcu_core_pkg::PC_RET);
      chk(prog_addr_o, 12'h300 + 12'(i));
    end
    pc(mcu_core_pkg::PC_RET);
    chk({stack_empty_o, prog_addr_o[10:0]}, 12'hb00);
  endtask : t_pc
  task automatic complete_run;
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : complete_run
  initial
  begin
    #50000;
    err_count++;
    complete_run();
  end
  initial
  begin
    repeat (2) @(posedge ref_clk_i);
    @(negedge ref_clk_i);
    rst_i = 1'b0;
    t_flags();
    t_regs();
    t_pc();
    complete_run();
  end
endmodule : mcu_core_regs_tb
bind mcu_core_regs mcu_core_regs_props u_mcu_core_regs_props (.*);
